// ---- abmux_top.v ----
/*
 * Address bus output stage with programmable upper pins.
 * Holds the registered address, strobe timing, port latches and the
 * one-hot acknowledge level decode. Pin 0 of the upper group has no
 * acknowledge level, and function code 3 leaves an upper pin undriven.
 * Assumes a bus cycle sequencer that raises cyc_start for one ref_clk
 * cycle while idle and cyc_end for one cycle once the strobe is out,
 * and far-side logic that resolves pins shared between functions.
 */
// Contract
// - Drive byte address at bus cycle start
// - Address stable while strobe asserted
// - Lower lines three-state, not control space
// - Upper pins: address, port or acknowledge
// - Port function is software parallel port
// - Acknowledge cycle asserts one matching level
// - Strobe follows cycle start by half period; code waits one full ref_clk cycle
`timescale 1ns/10ps
`include "abmux_consts.vh"

module abmux_top (
  ref_clk,
  sys_rst,
  cyc_start,
  cyc_end,
  cyc_addr,
  cyc_space,
  cyc_iack,
  cyc_level,
  bus_enable,
  upper_fn_sel,
  port_out_data,
  port_dir,
  upper_pin_in,
  lower_address_lines,
  lower_address_oe,
  upper_address_lines,
  upper_address_oe,
  upper_pin_gpio_port,
  int_level_acknowledge_lines,
  address_strobe_n,
  cycle_active
);
  input  wire                  ref_clk;                     // System clock, 25 MHz
  input  wire                  sys_rst;                     // Async reset, high
  input  wire                  cyc_start;                   // One-cycle start pulse
  input  wire                  cyc_end;                     // One-cycle end pulse
  input  wire [31:0]           cyc_addr;                    // Address of (first) byte
  input  wire [3:0]            cyc_space;                   // Access space code
  input  wire                  cyc_iack;                    // Cycle is acknowledge
  input  wire [2:0]            cyc_level;                   // Level acknowledged, 1..7
  input  wire                  bus_enable;                  // Device owns the bus
  input  wire [15:0]           upper_fn_sel;                // Two bits per upper pin
  input  wire [7:0]            port_out_data;               // Port output latch value
  input  wire [7:0]            port_dir;                    // Port direction per pin
  input  wire [7:0]            upper_pin_in;                // Upper pin levels seen
  output reg  [23:0]           lower_address_lines;         // Lower address out
  output wire                  lower_address_oe;            // Lower address enable
  output wire [7:0]            upper_address_lines;         // Upper pin out levels
  output wire [7:0]            upper_address_oe;            // Upper pin enables
  output reg  [7:0]            upper_pin_gpio_port;         // Port input value read
  output reg  [6:0]            int_level_acknowledge_lines; // Levels 7..1, high asserted
  output reg                   address_strobe_n;            // Strobe, active low
  output wire                  cycle_active;                // Bus cycle in progress

  // One-hot cycle states; the half-period strobe delay becomes one
  // full ref_clk cycle since only rising edges are available
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_SETUP = 3'b010;
  localparam [2:0] ST_STRB  = 3'b100;

  reg  [2:0]  state_r;       // Cycle state
  reg  [2:0]  state_nxt;     // Next state
  reg  [7:0]  upper_addr_r;  // Upper address bits held
  reg         ctrl_space_r;  // Cycle is in control space
  reg         iack_cyc_r;    // Cycle is an acknowledge
  reg  [2:0]  level_r;       // Level held for the cycle
  // Port latches and acknowledge look-ahead
  reg  [7:0]  port_out_r;    // Port output latch
  reg  [7:0]  port_dir_r;    // Port direction latch
  wire        ack_cyc_w;     // Acknowledge wanted next cycle
  wire [2:0]  ack_lvl_w;     // Level to decode next cycle

  // Decoder for the acknowledge outputs, whose lines also feed the pin drive
  function [6:0] abmux_level_dec;
    input [2:0] lvl;
    integer i;
    begin
      // Level zero means none and decodes to no line
      abmux_level_dec = `ABMUX_ACK_NONE;
      for (i = 1; i <= `ABMUX_ACK_W; i = i + 1) begin
        if (lvl == i[2:0]) begin
          abmux_level_dec[i - 1] = 1'b1;
        end
      end
    end
  endfunction

  // Next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      // Wait here; a start is taken only in this state
      ST_IDLE: begin
        if (cyc_start) begin
          state_nxt = ST_SETUP;
        end
      end
      // Address is out for one cycle before the strobe
      ST_SETUP: begin
        state_nxt = ST_STRB;
      end
      // Hold until the sequencer ends the cycle
      ST_STRB: begin
        if (cyc_end) begin
          state_nxt = ST_IDLE;
        end
      end
      // Unused one-hot codes fall back to idle
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State, address capture and strobe; address loads only at start
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Strobe negated and nothing captured while in reset
      state_r             <= ST_IDLE;
      lower_address_lines <= `ABMUX_LOW_ZERO;
      upper_addr_r        <= `ABMUX_UP_ZERO;
      ctrl_space_r        <= 1'b0;
      iack_cyc_r          <= 1'b0;
      level_r             <= `ABMUX_LEVEL_NONE;
      address_strobe_n    <= 1'b1;
    end else begin
      // One-hot state loads its next value every edge
      state_r <= state_nxt;
      // A start is taken only while idle; a refused one leaves all as is
      if (state_r == ST_IDLE && cyc_start) begin
        // Captured once so the address cannot move under the strobe
        lower_address_lines <= cyc_addr[`ABMUX_LOW_W-1:0];
        upper_addr_r        <= cyc_addr[`ABMUX_UP_MSB:`ABMUX_UP_LSB];
        ctrl_space_r        <= (cyc_space == `ABMUX_SPACE_CTRL);
        iack_cyc_r          <= cyc_iack;
        level_r             <= cyc_level;
      end else if (state_r == ST_STRB && cyc_end) begin
        // The held acknowledge flag ends with the cycle
        iack_cyc_r <= 1'b0;
      end
      // Strobe asserted one cycle after setup, dropped at cycle end
      address_strobe_n <= ~(state_nxt == ST_STRB);
    end
  end

  // A start is only seen while idle; otherwise the held flag decides,
  // so a refused start can never raise a level in a plain cycle
  assign ack_cyc_w = (state_r == ST_IDLE) ? (cyc_start & cyc_iack) : iack_cyc_r;
  assign ack_lvl_w = (state_r == ST_IDLE) ? cyc_level : level_r;

  // Acknowledge level outputs, one-hot only during acknowledge cycles
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_level_acknowledge_lines <= `ABMUX_ACK_NONE;
    end else if (state_nxt != ST_IDLE && ack_cyc_w) begin
      // Registered so the level pins cannot glitch between cycles
      int_level_acknowledge_lines <= abmux_level_dec(ack_lvl_w);
    end else begin
      // Plain cycles and the cycle end both clear every level
      int_level_acknowledge_lines <= `ABMUX_ACK_NONE;
    end
  end

  // Port latches and input sampling; inputs are synchronous to ref_clk.
  // Latching the output value keeps the pin data coming from a flop.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_out_r          <= `ABMUX_UP_ZERO;
      port_dir_r          <= `ABMUX_UP_ZERO;
      upper_pin_gpio_port <= `ABMUX_UP_ZERO;
    end else begin
      port_out_r          <= port_out_data;
      port_dir_r          <= port_dir;
      // Read back regardless of direction, as software may want both
      upper_pin_gpio_port <= upper_pin_in;
    end
  end

  // Cycle in progress from the edge after the start to the end
  assign cycle_active = (state_r != ST_IDLE);
  // Lower lines float in control space and when the bus is not ours
  assign lower_address_oe = bus_enable & cycle_active & ~ctrl_space_r;

  // Upper pins: eight cells; acknowledge pins carry levels 1..7 on
  // pins 1..7, pin 0 has no level and stays negated
  genvar g;
  generate
    for (g = 0; g < `ABMUX_UP_W; g = g + 1) begin : g_pin
      wire iack_w;
      // Pin 0 has no level to carry
      if (g == 0) begin : g_nolvl
        assign iack_w = 1'b0;
      end else begin : g_lvl
        assign iack_w = int_level_acknowledge_lines[g - 1];
      end
      // Each cell picks its source from its two function bits
      abmux_pin_cell u_cell (
        .fn_sel   (upper_fn_sel[2*g+1:2*g]),
        .addr_bit (upper_addr_r[g]),
        .addr_oe  (lower_address_oe),
        .port_bit (port_out_r[g]),
        .port_dir (port_dir_r[g]),
        .iack_bit (iack_w),
        .pin_out  (upper_address_lines[g]),
        .pin_oe   (upper_address_oe[g])
      );
    end
  endgenerate
endmodule

// ---- abmux_consts.vh ----
/*
 * Constants for the address bus output and acknowledge level mux.
 * Assumes inclusion by abmux_top.v and abmux_pin_cell.v only.
 */
`ifndef ABMUX_CONSTS_VH
`define ABMUX_CONSTS_VH

// Bus widths
`define ABMUX_LOW_W       24
`define ABMUX_UP_W        8
`define ABMUX_ADDR_W      32
`define ABMUX_UP_LSB      24
`define ABMUX_UP_MSB      31
`define ABMUX_LEVEL_W     3
`define ABMUX_SPACE_W     4

// Per-pin function select codes, two bits per upper pin
`define ABMUX_FN_W        2
`define ABMUX_FN_ADDR     2'h0
`define ABMUX_FN_PORT     2'h1
`define ABMUX_FN_IACK     2'h2
`define ABMUX_FN_RSVD     2'h3

// Access space code of the processor control space
`define ABMUX_SPACE_CTRL  4'h7

// Zero levels
`define ABMUX_LOW_ZERO    24'h000000
`define ABMUX_UP_ZERO     8'h00
`define ABMUX_LEVEL_NONE  3'h0

// Acknowledge level lines, levels 1..7
`define ABMUX_ACK_W       7
`define ABMUX_ACK_NONE    7'h00

`endif

// ---- abmux_pin_cell.v ----
/*
 * One upper address pin: selects address bit, port bit or acknowledge
 * level according to its function code. Combinational only.
 * Assumes the caller registers the inputs it supplies.
 */
`timescale 1ns/10ps
`include "abmux_consts.vh"

module abmux_pin_cell (
  fn_sel,
  addr_bit,
  addr_oe,
  port_bit,
  port_dir,
  iack_bit,
  pin_out,
  pin_oe
);
  input  wire [1:0] fn_sel;   // Function of this pin
  input  wire       addr_bit; // Registered address bit
  input  wire       addr_oe;  // Address bus enable
  input  wire       port_bit; // Port output latch bit
  input  wire       port_dir; // Port direction, high drives
  input  wire       iack_bit; // Acknowledge level, high asserted
  output reg        pin_out;  // Pin level driven
  output reg        pin_oe;   // Pin drive enable

  // Select source; acknowledge is active low on the wire
  always @* begin
    pin_out = 1'b0;
    pin_oe  = 1'b0;
    if (fn_sel == `ABMUX_FN_ADDR) begin
      pin_out = addr_bit;
      pin_oe  = addr_oe;
    end else if (fn_sel == `ABMUX_FN_PORT) begin
      pin_out = port_bit;
      pin_oe  = port_dir;
    end else if (fn_sel == `ABMUX_FN_IACK) begin
      // Always driven so a negated line reads high, never floats
      pin_out = ~iack_bit;
      pin_oe  = 1'b1;
    end
  end
endmodule

// ---- abmux_monitor.sv ----
/* Port checker for abmux_top.
   Assumes a bind onto abmux_top. */
`timescale 1ns/10ps
module abmux_monitor (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        cyc_start,
  input wire        cyc_end,
  input wire [31:0] cyc_addr,
  input wire [3:0]  cyc_space,
  input wire        cyc_iack,
  input wire [2:0]  cyc_level,
  input wire        bus_enable,
  input wire [15:0] upper_fn_sel,
  input wire [23:0] lower_address_lines,
  input wire        lower_address_oe,
  input wire [7:0]  upper_address_lines,
  input wire [7:0]  upper_address_oe,
  input wire [6:0]  int_level_acknowledge_lines,
  input wire        address_strobe_n,
  input wire        cycle_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A start only counts while idle
  wire start_taken = cyc_start && !cycle_active;

  a_strobe_delay:
    assert property (start_taken |=> cycle_active && address_strobe_n ##1 !address_strobe_n)
    else $error("strobe timing wrong");
  a_addr_drive:
    assert property (start_taken |=> lower_address_lines == $past(cyc_addr[23:0]))
    else $error("address not driven");
  a_addr_stable:
    assert property (!address_strobe_n |=> address_strobe_n || $stable(lower_address_lines))
    else $error("address moved under strobe");
  a_strobe_end:
    assert property (!address_strobe_n && cyc_end |=> address_strobe_n && !cycle_active)
    else $error("cycle did not end");
  a_lower_oe:
    assert property (start_taken |=> lower_address_oe == (bus_enable && $past(cyc_space) != 4'h7))
    else $error("lower enable wrong");
  a_ack_level:
    assert property (start_taken |=> int_level_acknowledge_lines ==
      ($past(cyc_iack) ? 7'h01 << ($past(cyc_level) - 3'h1) : 7'h00))
    else $error("acknowledge level wrong");
  a_ack_idle:
    assert property (!cycle_active |-> int_level_acknowledge_lines == 7'h00)
    else $error("acknowledge outside cycle");
  a_ack_pin:
    assert property (upper_fn_sel[15:14] == 2'h2 |->
      upper_address_oe[7] && upper_address_lines[7] == !int_level_acknowledge_lines[6])
    else $error("acknowledge pin wrong");
endmodule

// ---- abmux_periph.sv ----
/* Far side: pin wiring and an acknowledge decoder.
   Assumes the upper pin drives of abmux_top. */
`timescale 1ns/10ps
module abmux_periph (
  input  wire [7:0]  upper_address_lines,
  input  wire [7:0]  upper_address_oe,
  input  wire [15:0] upper_fn_sel,
  input  wire [7:0]  ext_drive,
  output wire [7:0]  pin_level,
  output reg  [2:0]  ack_seen
);
  integer i;
  // Undriven pins follow the outside driver, so a lost enable shows
  assign pin_level = (upper_address_oe & upper_address_lines) | (~upper_address_oe & ext_drive);
  // Level taken from acknowledge pins alone, no address decode
  always @* begin
    ack_seen = 3'h0;
    for (i = 1; i < 8; i = i + 1)
      if (upper_fn_sel[2*i+1 -: 2] == 2'h2 && !pin_level[i]) ack_seen = i[2:0];
  end
endmodule

// ---- abmux_top_tb.sv ----
/* Bench for abmux_top with far-side model and checker.
   Assumes the design and both models are compiled first. */
`timescale 1ns/10ps
module abmux_top_tb;
  reg         ref_clk = 1'b0, sys_rst = 1'b1, cyc_start = 1'b0, cyc_end = 1'b0;
  reg         cyc_iack = 1'b0, bus_enable = 1'b1;
  reg  [31:0] cyc_addr = 32'h0;
  reg  [3:0]  cyc_space = 4'h0;
  reg  [2:0]  cyc_level = 3'h0;
  reg  [15:0] upper_fn_sel = 16'h0;
  reg  [7:0]  port_out_data = 8'h0, port_dir = 8'h0, ext_drive = 8'h0;
  wire [7:0]  upper_pin_in, upper_address_lines, upper_address_oe, upper_pin_gpio_port;
  wire [23:0] lower_address_lines;
  wire [6:0]  int_level_acknowledge_lines;
  wire [2:0]  ack_seen;
  wire        lower_address_oe, address_strobe_n, cycle_active;
  integer     error_cnt = 0, cmp_count = 0, k;
  always #20 ref_clk = ~ref_clk;
  abmux_top abmux_top_inst (
    .ref_clk                     (ref_clk),
    .sys_rst                     (sys_rst),
    .cyc_start                   (cyc_start),
    .cyc_end                     (cyc_end),
    .cyc_addr                    (cyc_addr),
    .cyc_space                   (cyc_space),
    .cyc_iack                    (cyc_iack),
    .cyc_level                   (cyc_level),
    .bus_enable                  (bus_enable),
    .upper_fn_sel                (upper_fn_sel),
    .port_out_data               (port_out_data),
    .port_dir                    (port_dir),
    .upper_pin_in                (upper_pin_in),
    .lower_address_lines         (lower_address_lines),
    .lower_address_oe            (lower_address_oe),
    .upper_address_lines         (upper_address_lines),
    .upper_address_oe            (upper_address_oe),
    .upper_pin_gpio_port         (upper_pin_gpio_port),
    .int_level_acknowledge_lines (int_level_acknowledge_lines),
    .address_strobe_n            (address_strobe_n),
    .cycle_active                (cycle_active)
  );
  abmux_periph abmux_periph_inst (.upper_address_lines, .upper_address_oe, .upper_fn_sel,
    .ext_drive, .pin_level(upper_pin_in), .ack_seen);
  task tick; @(posedge ref_clk) #1; endtask
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Start a cycle just after an edge; returns with the strobe asserted
  task open_cyc(input [31:0] a, input [3:0] s, input q, input [2:0] l);
    begin
      cyc_addr = a;
      cyc_space = s;
      cyc_iack = q;
      cyc_level = l;
      cyc_start = 1'b1;
      tick;
      cyc_start = 1'b0;
      check("strobe_early", address_strobe_n, 1);
      check("lower_addr", lower_address_lines, a[23:0]);
      check("active_on", cycle_active, 1);
      tick;
      check("strobe_on", address_strobe_n, 0);
    end
  endtask
  task close_cyc;
    begin
      cyc_end = 1'b1;
      tick;
      cyc_end = 1'b0;
      check("strobe_off", address_strobe_n, 1);
      check("ack_after", int_level_acknowledge_lines, 0);
      check("active_off", cycle_active, 0);
    end
  endtask
  // Address cycles, a refused restart, a released bus and control space
  task t_addr;
    begin
      open_cyc(32'h9a5c3e71, 4'h5, 1'b0, 3'h0);
      cyc_addr = 32'h0;
      cyc_iack = 1'b1;
      cyc_level = 3'h4;
      cyc_start = 1'b1;
      tick;
      cyc_start = 1'b0;
      check("addr_held", lower_address_lines, 24'h5c3e71);
      check("ack_refused", int_level_acknowledge_lines, 0);
      check("upper_addr", upper_address_lines, 8'h9a);
      check("lower_oe", lower_address_oe, 1);
      close_cyc;
      bus_enable = 1'b0;
      open_cyc(32'h00123456, 4'h5, 1'b0, 3'h0);
      check("oe_released", lower_address_oe, 0);
      close_cyc;
      bus_enable = 1'b1;
      open_cyc(32'h00fffff0, 4'h7, 1'b0, 3'h0);
      check("oe_ctrl", lower_address_oe, 0);
      check("up_oe_ctrl", upper_address_oe, 8'h00);
      close_cyc;
    end
  endtask
  // Every acknowledge level, then a plain cycle with a level present
  task t_ack;
    begin
      upper_fn_sel = 16'haaaa;
      for (k = 1; k < 8; k = k + 1) begin
        open_cyc(32'h0, 4'h7, 1'b1, k[2:0]);
        check("ack_lines", int_level_acknowledge_lines, 7'h01 << (k - 1));
        check("ack_pins", upper_address_lines[7:1], {~(7'h01 << (k - 1))});
        check("ack_seen", ack_seen, k);
        close_cyc;
      end
      open_cyc(32'h0, 4'h5, 1'b0, 3'h3);
      check("ack_none", int_level_acknowledge_lines, 0);
      close_cyc;
    end
  endtask
  // Half the port drives, half is read back from outside
  task t_port;
    begin
      upper_fn_sel = 16'h5555;
      port_dir = 8'h0f;
      port_out_data = 8'ha5;
      ext_drive = 8'h3c;
      tick;
      check("port_oe", upper_address_oe, 8'h0f);
      tick;
      check("port_in", upper_pin_gpio_port, 8'h35);
      upper_fn_sel = 16'hffff;
      tick;
      check("idle_oe", upper_address_oe, 8'h00);
    end
  endtask
  // Reset inside an acknowledge cycle, then a cycle at the first edge after release
  task t_reset;
    begin
      open_cyc(32'h0, 4'h7, 1'b1, 3'h5);
      sys_rst = 1'b1;
      tick;
      check("rst_strobe", address_strobe_n, 1);
      check("rst_active", cycle_active, 0);
      check("rst_ack", int_level_acknowledge_lines, 0);
      check("rst_seen", ack_seen, 0);
      sys_rst = 1'b0;
      open_cyc(32'h00abcdef, 4'h5, 1'b0, 3'h0);
      check("rst_pins", upper_address_lines, 8'hff);
      close_cyc;
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    t_addr;
    t_ack;
    t_reset;
    t_port;
    stop_test;
  end
  // Whole run needs about 63 cycles; the limit allows 500
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
endmodule
bind abmux_top abmux_monitor abmux_monitor_inst (
  .ref_clk                     (ref_clk),
  .sys_rst                     (sys_rst),
  .cyc_start                   (cyc_start),
  .cyc_end                     (cyc_end),
  .cyc_addr                    (cyc_addr),
  .cyc_space                   (cyc_space),
  .cyc_iack                    (cyc_iack),
  .cyc_level                   (cyc_level),
  .bus_enable                  (bus_enable),
  .upper_fn_sel                (upper_fn_sel),
  .lower_address_lines         (lower_address_lines),
  .lower_address_oe            (lower_address_oe),
  .upper_address_lines         (upper_address_lines),
  .upper_address_oe            (upper_address_oe),
  .int_level_acknowledge_lines (int_level_acknowledge_lines),
  .address_strobe_n            (address_strobe_n),
  .cycle_active                (cycle_active)
);
